// >>> lfo_loop_fault_output.v
// Operation
// - Watch each loop for open, short and over-25-percent inductance change.
// - While a fault is present, flash the output and fault indicators.
// - Show the letter F while a loop fault is present.
// - Flash count per repetition: one open, two short, three change.
// - When open or short heals, detect and display return to normal.
// - After clearing, fault indicator keeps flashing the last fault code.
// - On inductance change, wait two seconds, retune, resume detection.
// - Mode button cycles presence, pulse, forced call, channel off.
// - Presence offers 30 minute and 120 minute hold times.
// - Pulse mode emits one 125 ms pulse per vehicle entering.
// - Forced call mode holds the call output on continuously.
// - Channel off disables detection and stops the oscillator.
// - Optional: status line held ON while the channel is off.
// - Each channel has a status line carrying pulse-width fault codes.
// - Watchdog or supply failure holds the status line OFF, high.
`timescale 1ns/10ps
`default_nettype none
`include "lfo_consts.vh"

module lfo_loop_fault_output #(
    parameter MS_CYCLES = `LFO_MS_NS / `LFO_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // Register port
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdData,
    output reg         irq,
    // Loop measurement, four 16-bit counts packed low channel first
    input  wire [3:0]  loopOpen,
    input  wire [3:0]  loopShort,
    input  wire [63:0] loopCount,
    input  wire [3:0]  vehiclePresent,
    // Front panel and supervision
    input  wire [3:0]  modeButton,
    input  wire        watchdogFail,
    input  wire        supplyFail,
    // Channel outputs
    output reg  [3:0]  callOut,
    output reg  [3:0]  outIndicator,
    output reg  [3:0]  loopFaultIndicator,
    output reg  [3:0]  vehicleDetectIndicator,
    output reg  [3:0]  displayFault,
    output reg  [3:0]  oscEnable,
    output reg  [3:0]  statusLine
);

    // ------------------------------------------------------------
    // Mode states, one-hot
    // ------------------------------------------------------------
    localparam [4:0] MD_SHORT = 5'h01;
    localparam [4:0] MD_LONG  = 5'h02;
    localparam [4:0] MD_PULSE = 5'h04;
    localparam [4:0] MD_CALL  = 5'h08;
    localparam [4:0] MD_OFF   = 5'h10;

    // Short and long presence are separate states, one press apart.

    // Hold times and pulse length, in milliseconds.
    localparam [31:0] SHORT_HOLD = `LFO_SHORT_HOLD_MIN * `LFO_MS_PER_MIN;
    localparam [31:0] LONG_HOLD  = `LFO_LONG_HOLD_MIN * `LFO_MS_PER_MIN;
    localparam [31:0] PULSE_WIDE = `LFO_PULSE_MS;

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    // One shared tick keeps all channel timers in step for one counter.
    reg [17:0] msDiv;
    reg        msTick;
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            msDiv  <= 18'h00000;
            msTick <= 1'b0;
        end
        else if (msDiv == MS_CYCLES - 1)
        begin
            msDiv  <= 18'h00000;
            msTick <= 1'b1;
        end
        else
        begin
            msDiv  <= msDiv + 18'h00001;
            msTick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [3:0]  offStatusOn;
    reg  [3:0]  irqStat;
    reg  [3:0]  irqMask;
    wire [3:0]  faultOnset;
    wire [31:0] chanState;

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            offStatusOn <= `LFO_CTRL_RESET;
            irqMask     <= `LFO_MASK_RESET;
            irqStat     <= 4'h0;
            irq         <= 1'b0;
            regRdData   <= 32'h00000000;
        end
        else
        begin
            if (regWr && regAddr == `LFO_REG_CTRL)
                offStatusOn <= regWrData[3:0];
            if (regWr && regAddr == `LFO_REG_IRQ_MASK)
                irqMask <= regWrData[3:0];
            // A new fault in the clearing cycle survives the clear.
            if (regWr && regAddr == `LFO_REG_IRQ_STAT)
                irqStat <= (irqStat & ~regWrData[3:0]) | faultOnset;
            else
                irqStat <= irqStat | faultOnset;
            irq <= |((irqStat | faultOnset) & irqMask);

            // Read data stand for one cycle only and are zero otherwise.
            if (!regRd)
                regRdData <= 32'h00000000;
            else if (regAddr == `LFO_REG_CTRL)
                regRdData <= {28'h0000000, offStatusOn};
            else if (regAddr == `LFO_REG_IRQ_STAT)
                regRdData <= {28'h0000000, irqStat};
            else if (regAddr == `LFO_REG_IRQ_MASK)
                regRdData <= {28'h0000000, irqMask};
            else if (regAddr == `LFO_REG_CHAN_STATE)
                regRdData <= chanState;
            else
                regRdData <= 32'h00000000;
        end
    end

    // Either failure overrides every pattern, so the unit sees steady OFF.
    wire failHold = watchdogFail | supplyFail;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    genvar ch;

    generate
        for (ch = 0; ch < 4; ch = ch + 1)
        begin : gChan
            reg  [4:0]  mode;
            reg  [15:0] nominal;
            reg         tuned;
            reg  [1:0]  lastCode;
            reg         drifting;
            reg  [10:0] retuneCnt;
            reg  [22:0] holdCnt;
            reg  [6:0]  pulseCnt;
            reg         prevPresent;
            reg         prevFault;
            reg  [8:0]  flashPh;
            reg  [2:0]  flashNum;
            reg  [7:0]  statCnt;

            wire [15:0] count = loopCount[16*ch+15:16*ch];
            wire [15:0] diff;
            wire        drift;
            wire [1:0]  nowCode;
            wire        faultNow;
            wire        flashLit;
            wire        detecting;
            wire [22:0] holdLimit;
            wire        holdUp;
            wire [7:0]  offLen;
            wire [31:0] offLenWide;

            // ------------------------------------------------------------
            // Fault classification
            // ------------------------------------------------------------
            assign detecting = (mode != MD_OFF);
            assign diff = (count > nominal) ? count - nominal : nominal - count;
            // Four times the change above the baseline is over a quarter.
            assign drift = tuned && detecting &&
                           ({diff, 2'b00} > {2'b00, nominal});
            // Priority is open, then short, then inductance change.
            assign nowCode = loopOpen[ch]  ? `LFO_FC_OPEN :
                             loopShort[ch] ? `LFO_FC_SHORT :
                             (drifting | drift) ? `LFO_FC_DRIFT :
                             `LFO_FC_NONE;
            assign faultNow = detecting && (nowCode != `LFO_FC_NONE);
            assign faultOnset[ch] = faultNow && !prevFault;

            // Lamps are lit for the first half of each code slot.
            assign flashLit = (flashNum < {1'b0, lastCode}) &&
                              (flashPh < `LFO_FLASH_LIT_MS);
            // The presence timer counts milliseconds against the hold time.
            assign holdLimit = (mode == MD_LONG) ? LONG_HOLD[22:0] :
                               SHORT_HOLD[22:0];
            assign holdUp = (holdCnt >= holdLimit);

            assign offLenWide = {30'h00000000, nowCode} * `LFO_STAT_UNIT_MS;
            assign offLen = offLenWide[7:0];
            assign chanState[8*ch+7:8*ch] =
                {faultNow, lastCode, mode};

            // ------------------------------------------------------------
            // Channel state and outputs
            // ------------------------------------------------------------
            always @(posedge clk_sys)
            begin
                if (sys_rst)
                begin
                    mode        <= MD_SHORT;
                    nominal     <= 16'h0000;
                    tuned       <= 1'b0;
                    lastCode    <= `LFO_FC_NONE;
                    drifting    <= 1'b0;
                    retuneCnt   <= 11'h000;
                    holdCnt     <= 23'h000000;
                    pulseCnt    <= 7'h00;
                    prevPresent <= 1'b0;
                    prevFault   <= 1'b0;
                    flashPh     <= 9'h000;
                    flashNum    <= 3'h0;
                    statCnt     <= 8'h00;

                    callOut[ch]                <= 1'b0;
                    outIndicator[ch]           <= 1'b0;
                    loopFaultIndicator[ch]     <= 1'b0;
                    vehicleDetectIndicator[ch] <= 1'b0;
                    displayFault[ch]           <= 1'b0;
                    oscEnable[ch]              <= 1'b0;
                    statusLine[ch]             <= 1'b1;
                end
                else
                begin
                    prevFault <= faultNow;

                    if (modeButton[ch])
                    begin
                        case (mode)
                            MD_SHORT: mode <= MD_LONG;
                            MD_LONG:  mode <= MD_PULSE;
                            MD_PULSE: mode <= MD_CALL;
                            MD_CALL:  mode <= MD_OFF;
                            default:  mode <= MD_SHORT;
                        endcase
                    end

                    if (faultNow)
                        lastCode <= nowCode;

                    // Retune and drift wait.
                    // A retune takes the live count as the new baseline.
                    if (!detecting)
                    begin
                        tuned     <= 1'b0;
                        drifting  <= 1'b0;
                        retuneCnt <= 11'h000;
                    end
                    else if (!tuned)
                    begin
                        nominal <= count;
                        tuned   <= 1'b1;
                    end
                    else if (drifting)
                    begin
                        if (retuneCnt == `LFO_RETUNE_MS - 1)
                        begin
                            nominal   <= count;
                            drifting  <= 1'b0;
                            retuneCnt <= 11'h000;
                        end
                        else if (msTick)
                            retuneCnt <= retuneCnt + 11'h001;
                    end
                    else if (drift)
                        drifting <= 1'b1;
                    else if (vehiclePresent[ch] && holdUp &&
                             (mode == MD_SHORT || mode == MD_LONG))
                        nominal <= count;

                    // Presence hold timer, counted in milliseconds.
                    if (!vehiclePresent[ch] || !(mode == MD_SHORT ||
                        mode == MD_LONG))
                        holdCnt <= 23'h000000;
                    else if (msTick && !holdUp)
                        holdCnt <= holdCnt + 23'h000001;
                    else if (holdUp && !drifting)
                        holdCnt <= 23'h000000;

                    // Pulse on each vehicle entry.
                    prevPresent <= vehiclePresent[ch];
                    if (mode == MD_PULSE && vehiclePresent[ch] &&
                        !prevPresent && !faultNow)
                        pulseCnt <= PULSE_WIDE[6:0];
                    else if (msTick && pulseCnt != 7'h00)
                        pulseCnt <= pulseCnt - 7'h01;

                    // Flash sequencer: code flashes, then two dark slots.
                    // The dark slots keep one repetition apart from the next.
                    if (lastCode == `LFO_FC_NONE)
                    begin
                        flashPh  <= 9'h000;
                        flashNum <= 3'h0;
                    end
                    else if (msTick)
                    begin
                        if (flashPh == `LFO_FLASH_SLOT_MS - 1)
                        begin
                            flashPh <= 9'h000;
                            if (flashNum == {1'b0, lastCode} + 3'h1)
                                flashNum <= 3'h0;
                            else
                                flashNum <= flashNum + 3'h1;
                        end
                        else
                            flashPh <= flashPh + 9'h001;
                    end

                    // Status pattern counter, restarted with no fault.
                    // The first OFF interval may be short by up to one tick.
                    if (!faultNow)
                        statCnt <= 8'h00;
                    else if (msTick)
                    begin
                        if (statCnt >= offLen + `LFO_STAT_UNIT_MS - 1)
                            statCnt <= 8'h00;
                        else
                            statCnt <= statCnt + 8'h01;
                    end

                    // Outputs.
                    // A fault forces the call on, so the controller is safe.
                    oscEnable[ch] <= detecting;
                    if (!detecting)
                        callOut[ch] <= 1'b0;
                    else if (faultNow)
                        callOut[ch] <= 1'b1;
                    else if (mode == MD_CALL)
                        callOut[ch] <= 1'b1;
                    else if (mode == MD_PULSE)
                        callOut[ch] <= (pulseCnt != 7'h00);
                    else
                        callOut[ch] <= vehiclePresent[ch] && !holdUp;
                    // Without a fault the output lamp shows vehicle presence, or stays lit in forced call mode.
                    outIndicator[ch] <= faultNow ? flashLit :
                                        (detecting && (mode == MD_CALL ||
                                        vehiclePresent[ch]));
                    loopFaultIndicator[ch] <= flashLit;
                    // The detect lamp is dark while a fault is present.
                    vehicleDetectIndicator[ch] <= detecting &&
                        vehiclePresent[ch] && !faultNow;
                    displayFault[ch] <= faultNow;

                    // Status line: high is OFF, low is ON.
                    if (failHold)
                        statusLine[ch] <= 1'b1;
                    else if (!detecting)
                        statusLine[ch] <= !offStatusOn[ch];
                    else if (faultNow)
                        statusLine[ch] <= (statCnt < offLen);
                    else
                        statusLine[ch] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// >>> lfo_consts.vh
`ifndef LFO_CONSTS_VH
`define LFO_CONSTS_VH

// ------------------------------------------------------------
// Register offsets and reset values
// ------------------------------------------------------------
`define LFO_REG_CTRL       8'h00
`define LFO_REG_IRQ_STAT   8'h04
`define LFO_REG_IRQ_MASK   8'h08
`define LFO_REG_CHAN_STATE 8'h0C
`define LFO_CTRL_RESET     4'h0
`define LFO_MASK_RESET     4'h0

// ------------------------------------------------------------
// Fault codes, equal to the flash count
// ------------------------------------------------------------
`define LFO_FC_NONE  2'h0
`define LFO_FC_OPEN  2'h1
`define LFO_FC_SHORT 2'h2
`define LFO_FC_DRIFT 2'h3

// ------------------------------------------------------------
// Timing, in the unit named, and the clock period
// ------------------------------------------------------------
`define LFO_CLK_PERIOD_NS 5
`define LFO_MS_NS         1000000
`define LFO_RETUNE_MS     2000
`define LFO_SHORT_HOLD_MIN 30
`define LFO_LONG_HOLD_MIN  120
`define LFO_MS_PER_MIN    60000
`define LFO_PULSE_MS      125
`define LFO_FLASH_SLOT_MS 500
`define LFO_FLASH_LIT_MS  250
`define LFO_STAT_UNIT_MS  50

`endif

// >>> lfo_loop_fault_output_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module lfo_loop_fault_output_assertions #(
    parameter MS_CYCLES = 4
) (
    // Inputs
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        regRd,
    input wire logic [3:0]  loopOpen,
    input wire logic [3:0]  loopShort,
    input wire logic [3:0]  modeButton,
    input wire logic        watchdogFail,
    input wire logic        supplyFail,
    // Outputs
    input wire logic [31:0] regRdData,
    input wire logic [3:0]  callOut,
    input wire logic [3:0]  displayFault,
    input wire logic [3:0]  oscEnable,
    input wire logic [3:0]  statusLine
);
    logic        prevLine;
    logic [15:0] runLen;
    logic [1:0]  runCode;
    wire         flip = statusLine[0] != prevLine;
    wire         quiet = watchdogFail | supplyFail | ~oscEnable[0];
    wire [1:0]   liveCode = quiet ? 2'h0 : loopOpen[0] ? 2'h1 :
                            loopShort[0] ? 2'h2 : 2'h0;
    wire         hit = oscEnable[0] & (loopOpen[0] | loopShort[0]) &
                       ~modeButton[0];

    // Run length of channel 0 status level, kept only for steady faults.
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            prevLine <= 1'b1;
            runLen <= 16'h0;
            runCode <= 2'h0;
        end
        else
        begin
            prevLine <= statusLine[0];
            runLen <= flip ? 16'h1 : runLen + 16'h1;
            // The first OFF run of a fault may start mid tick: not measured.
            runCode <= flip ? ((runCode != 2'h0 || !statusLine[0]) ?
                               liveCode : 2'h0) :
                       (liveCode == runCode ? runCode : 2'h0);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence offEnd;
        flip && prevLine && runCode != 2'h0;
    endsequence
    sequence onEnd;
        flip && !prevLine && runCode != 2'h0;
    endsequence

    a_off_width: assert property (offEnd |-> runLen == 50 * MS_CYCLES * runCode)
        else $error("status OFF width wrong");
    a_on_width: assert property (onEnd |-> runLen == 50 * MS_CYCLES)
        else $error("status ON width wrong");
    a_fail_status_off: assert property ((watchdogFail || supplyFail) |=> statusLine == 4'hF)
        else $error("status not OFF on failure");
    a_fault_letter: assert property (hit |=> displayFault[0])
        else $error("fault letter missing");
    a_fault_calls: assert property (hit |=> callOut[0])
        else $error("fault did not force call");
    a_status_idle: assert property (oscEnable[0] && !displayFault[0] && !$past(watchdogFail) && !$past(supplyFail) |-> !statusLine[0])
        else $error("status not ON without fault");
    a_off_quiet: assert property (!oscEnable[3] |-> !callOut[3] && !displayFault[3])
        else $error("channel off still active");
    a_read_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data outside read slot");
endmodule
`default_nettype wire

// >>> lfo_biu_model.sv
`timescale 1ns/10ps
`default_nettype none
module lfo_biu_model #(
    parameter MS_CYCLES = 4
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Status lines in, decoded results out
    input  wire logic [3:0]  statusLine,
    output var  logic [31:0] offMs,
    output var  logic [3:0]  failSeen
);
    logic [15:0] runCnt [4];

    // Longest pattern OFF is 150 ms, so anything past 200 ms is steady.
    always @(posedge clk_sys)
    begin
        for (int c = 0; c < 4; c++)
        begin
            runCnt[c] <= (sys_rst || !statusLine[c]) ? 16'h0 : runCnt[c] + 16'h1;
            if (sys_rst)
                offMs[c*8 +: 8] <= 8'h0;
            else if (!statusLine[c] && runCnt[c] != 16'h0)
                offMs[c*8 +: 8] <= 8'(runCnt[c] / MS_CYCLES);
            failSeen[c] <= !sys_rst && runCnt[c] > 16'(200 * MS_CYCLES);
        end
    end
endmodule
`default_nettype wire

// >>> test_loop_detector_fault_output.sv
`timescale 1ns/10ps
`default_nettype none
`include "lfo_consts.vh"
module test_loop_detector_fault_output;
    localparam MS = 4;
    logic        clk_sys, sys_rst, regWr, regRd, irq, watchdogFail, supplyFail;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData, offMs, v;
    logic [63:0] loopCount;
    logic [3:0]  loopOpen, loopShort, vehiclePresent, modeButton, failSeen;
    logic [3:0]  callOut, outInd, fltInd, detInd, dispF, oscEn, statusLine;
    logic [7:0]  modeSeq [5] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h01};
    int          errors, checks_done, cyc, f, o, n;

    lfo_loop_fault_output #(.MS_CYCLES(MS)) lfo_loop_fault_output_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .irq(irq), .loopOpen(loopOpen),
        .loopShort(loopShort), .loopCount(loopCount),
        .vehiclePresent(vehiclePresent), .modeButton(modeButton),
        .watchdogFail(watchdogFail), .supplyFail(supplyFail),
        .callOut(callOut), .outIndicator(outInd),
        .loopFaultIndicator(fltInd), .vehicleDetectIndicator(detInd),
        .displayFault(dispF), .oscEnable(oscEn), .statusLine(statusLine));
    lfo_biu_model #(.MS_CYCLES(MS)) lfo_biu_model_inst (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .statusLine(statusLine), .offMs(offMs),
        .failSeen(failSeen));

    task conclude();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task waitc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    task press(input int ch);
        @(posedge clk_sys);
        modeButton[ch] <= 1'b1;
        @(posedge clk_sys);
        modeButton[ch] <= 1'b0;
        waitc(2);
    endtask
    // Counts rising flashes of the fault and output lamps over a window.
    task flashes(input int ch, input int len);
        logic pf, po;
        pf = fltInd[ch];
        po = outInd[ch];
        f = 0;
        o = 0;
        repeat (len)
        begin
            waitc(1);
            f += (fltInd[ch] && !pf);
            o += (outInd[ch] && !po);
            pf = fltInd[ch];
            po = outInd[ch];
        end
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 70000)
        begin
            errors++;
            conclude();
        end
    end

    initial
    begin
        {regWr, regRd, watchdogFail, supplyFail} = '0;
        {regAddr, regWrData, loopOpen, loopShort} = '0;
        {vehiclePresent, modeButton} = '0;
        loopCount = {4{16'h1000}};
        sys_rst = 1'b1;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        waitc(4);
        rd(`LFO_REG_CHAN_STATE, v); chk("modes", 32'h01010101, v);
        rd(`LFO_REG_CTRL, v); chk("ctrl", 32'h0, v);
        rd(8'h10, v); chk("unmapped", 32'h0, v);
        chk("idle status", 32'h0, statusLine);
        wr(`LFO_REG_IRQ_MASK, 32'h0000000F);
        rd(`LFO_REG_IRQ_MASK, v); chk("mask", 32'hF, v);
        loopCount[47:32] <= 16'h1400;
        waitc(10); chk("exact quarter", 32'h0, dispF);
        loopOpen <= 4'h1;
        waitc(3); chk("open F", 32'h1, dispF);
        chk("irq", 32'h1, irq);
        waitc(1000); chk("open off", 32'd50, offMs[7:0]);
        flashes(0, 6000); chk("open flt", 32'd1, f);
        chk("open out", 32'd1, o);
        rd(`LFO_REG_CHAN_STATE, v); chk("open state", 32'hA1, v[7:0]);
        wr(`LFO_REG_IRQ_STAT, 32'h1);
        waitc(3); chk("irq clear", 32'h0, irq);
        loopOpen <= 4'h0;
        waitc(3); chk("healed", 32'h0, dispF);
        chk("healed status", 32'h0, statusLine);
        flashes(0, 6000); chk("history", 32'd1, f);
        loopShort <= 4'h2;
        waitc(1200); chk("short off", 32'd100, offMs[15:8]);
        flashes(1, 8000); chk("short flt", 32'd2, f);
        loopShort <= 4'h0;
        loopCount[47:32] <= 16'h1401;
        waitc(1600); chk("drift off", 32'd150, offMs[23:16]);
        chk("drift F", 32'h4, dispF & 4'h4);
        waitc(6200); chk("drift wait", 32'h4, dispF & 4'h4);
        waitc(300); chk("retuned", 32'h0, dispF);
        flashes(2, 10000); chk("drift flt", 32'd3, f);
        rd(`LFO_REG_CHAN_STATE, v); chk("drift state", 32'h61, v[23:16]);
        for (n = 0; n < 2; n++)
        begin
            {watchdogFail, supplyFail} <= n ? 2'b01 : 2'b10;
            waitc(1000); chk("fail status", 32'hF, statusLine);
            chk("fail decode", 32'hF, failSeen);
            {watchdogFail, supplyFail} <= 2'b00;
            waitc(3); chk("fail gone", 32'h0, statusLine);
        end
        for (n = 0; n < 5; n++)
        begin
            press(3);
            rd(`LFO_REG_CHAN_STATE, v); chk("mode", modeSeq[n], v[31:24]);
            if (modeSeq[n] == 8'h08)
                chk("forced", 32'h8, callOut & 4'h8);
            if (modeSeq[n] == 8'h10)
            begin
                chk("osc off", 32'h0, oscEn & 4'h8);
                wr(`LFO_REG_CTRL, 32'h8);
                waitc(3); chk("off option", 32'h0, statusLine);
            end
        end
        vehiclePresent <= 4'h8;
        waitc(3); chk("presence", 32'h8, callOut & 4'h8);
        vehiclePresent <= 4'h0;
        press(3);
        press(3);
        vehiclePresent <= 4'h8;
        o = 0;
        repeat (1000)
        begin
            waitc(1);
            o += callOut[3];
        end
        chk("pulse width", 32'h1, (o >= 400 && o <= 600));
        conclude();
    end
endmodule

bind lfo_loop_fault_output lfo_loop_fault_output_assertions #(
    .MS_CYCLES(MS_CYCLES)) chk_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regRd(regRd), .loopOpen(loopOpen), .loopShort(loopShort),
    .modeButton(modeButton), .watchdogFail(watchdogFail),
    .supplyFail(supplyFail), .regRdData(regRdData), .callOut(callOut),
    .displayFault(displayFault), .oscEnable(oscEnable),
    .statusLine(statusLine));
`default_nettype wire
